// ===== core/alu_unit_pkg.sv
// Purpose: Constants and carriers for the data-processing execution unit
// Assumes: 32-bit datapath, combined program counter and status word
// Notes:   Register offsets serve the AHB-Lite control slave
package alu_unit_pkg;

  localparam int DATA_W = 32;

  // -------------------------------------------------------------------
  // Operation codes
  // -------------------------------------------------------------------
  localparam logic [3:0] OP_AND        = 4'h0;
  localparam logic [3:0] OP_XOR        = 4'h1;
  localparam logic [3:0] OP_SUB        = 4'h2;
  localparam logic [3:0] OP_REV_SUB    = 4'h3;
  localparam logic [3:0] OP_ADD        = 4'h4;
  localparam logic [3:0] OP_ADD_CARRY  = 4'h5;
  localparam logic [3:0] OP_SUB_CARRY  = 4'h6;
  localparam logic [3:0] OP_REV_SUB_C  = 4'h7;
  localparam logic [3:0] OP_TEST_BITS  = 4'h8;
  localparam logic [3:0] OP_TEST_EQUIV = 4'h9;
  localparam logic [3:0] OP_COMPARE    = 4'ha;
  localparam logic [3:0] OP_CMP_NEG    = 4'hb;
  localparam logic [3:0] OP_OR         = 4'hc;
  localparam logic [3:0] OP_MOVE       = 4'hd;
  localparam logic [3:0] OP_BIT_CLEAR  = 4'he;
  localparam logic [3:0] OP_MOVE_INV   = 4'hf;

  // Shift types
  localparam logic [1:0] SH_LEFT  = 2'h0;
  localparam logic [1:0] SH_RIGHT = 2'h1;
  localparam logic [1:0] SH_ARITH = 2'h2;
  localparam logic [1:0] SH_ROT   = 2'h3;

  // -------------------------------------------------------------------
  // Status word field positions inside the combined register
  // -------------------------------------------------------------------
  localparam int BIT_NEG   = 31;
  localparam int BIT_ZERO  = 30;
  localparam int BIT_CARRY = 29;
  localparam int BIT_OVF   = 28;
  localparam int BIT_IRQD  = 27;
  localparam int BIT_FIQD  = 26;
  localparam int PC_LO     = 2;
  localparam int PC_HI     = 25;
  localparam logic [31:0] STATUS_MASK = 32'hfc000003;
  localparam logic [31:0] FLAG_MASK   = 32'hf0000000;
  localparam logic [31:0] PC_MASK     = 32'h03fffffc;
  localparam logic [1:0]  MODE_USER   = 2'h0;
  localparam logic [1:0]  MODE_SUPER  = 2'h3;
  localparam logic [31:0] PCREG_RESET = 32'h0c000003;

  localparam logic [3:0] PC_INDEX = 4'hf;

  // -------------------------------------------------------------------
  // Register offsets (byte addresses)
  // -------------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR  = 8'h00;
  localparam logic [7:0] ADDR_OPA    = 8'h04;
  localparam logic [7:0] ADDR_OPB    = 8'h08;
  localparam logic [7:0] ADDR_COUNT  = 8'h0c;
  localparam logic [7:0] ADDR_CTRL   = 8'h10;
  localparam logic [7:0] ADDR_PCREG  = 8'h14;
  localparam logic [7:0] ADDR_RESULT = 8'h18;
  localparam logic [7:0] ADDR_STATE  = 8'h1c;

  // Control register bits: bit 0 start, bits 4:2 source selects pc, bit 5 destination pc
  localparam int CTRL_GO     = 0;
  localparam int CTRL_A_PC   = 2;
  localparam int CTRL_B_PC   = 3;
  localparam int CTRL_S_PC   = 4;
  localparam int CTRL_D_PC   = 5;

  // Decoded instruction fields
  typedef struct packed {
    logic [3:0] opcode;
    logic       imm_sel;
    logic       set_flags;
    logic [7:0] shift_amt;
    logic [1:0] shift_type;
    logic       reg_shift;
    logic       bit7;
    logic [3:0] rot_field;
    logic [7:0] imm8;
  } instr_s;

  // Shifter result
  typedef struct packed {
    logic [31:0] value;
    logic        carry;
  } shift_s;

endpackage

// ===== core/barrel_shifter.sv
// Purpose: Second-operand barrel shifter, register or rotated immediate
// Assumes: Pure combinational, amount already chosen by caller
// Notes:   Immediate amounts of zero carry the special encodings
`timescale 1ns/1ns
module barrel_shifter
  import alu_unit_pkg::*;
(
  input  wire logic [31:0] src,
  input  wire logic [7:0]  amount,
  input  wire logic [1:0]  kind,
  input  wire logic        by_reg,
  input  wire logic        imm_sel,
  input  wire logic [7:0]  imm8,
  input  wire logic [3:0]  rot_field,
  input  wire logic        carry_in,
  output shift_s           out
);

  logic [63:0] dbl;
  logic [4:0]  rot_amt;
  logic [4:0]  r5;

  always_comb begin
    out     = '{value: src, carry: carry_in};
    dbl     = '0;
    rot_amt = '0;
    r5      = amount[4:0];
    if (imm_sel) begin
      rot_amt = {rot_field, 1'b0};
      dbl = {24'h000000, imm8, 24'h000000, imm8} >> rot_amt;
      out.value = dbl[31:0];
      out.carry = (rot_amt == 5'h00) ? carry_in : dbl[31];
    end else if (amount == 8'h00) begin
      if (!by_reg && kind == SH_RIGHT) begin
        out = '{value: 32'h00000000, carry: src[31]};
      end else if (!by_reg && kind == SH_ARITH) begin
        out = '{value: {32{src[31]}}, carry: src[31]};
      end else if (!by_reg && kind == SH_ROT) begin
        out = '{value: {carry_in, src[31:1]}, carry: src[0]};
      end else begin
        out = '{value: src, carry: carry_in};
      end
    end else begin
      case (kind)
        SH_LEFT: begin
          if (amount > 8'd32) begin
            out = '{value: 32'h00000000, carry: 1'b0};
          end else if (amount == 8'd32) begin
            out = '{value: 32'h00000000, carry: src[0]};
          end else begin
            dbl = {32'h00000000, src} << r5;
            out = '{value: dbl[31:0], carry: dbl[32]};
          end
        end
        SH_RIGHT: begin
          if (amount > 8'd32) begin
            out = '{value: 32'h00000000, carry: 1'b0};
          end else if (amount == 8'd32) begin
            out = '{value: 32'h00000000, carry: src[31]};
          end else begin
            dbl = {src, 32'h00000000} >> r5;
            out = '{value: dbl[63:32], carry: dbl[31]};
          end
        end
        SH_ARITH: begin
          if (amount >= 8'd32) begin
            out = '{value: {32{src[31]}}, carry: src[31]};
          end else begin
            dbl = {{32{src[31]}}, src} >> r5;
            out = '{value: dbl[31:0], carry: src[r5 - 5'h01]};
          end
        end
        default: begin
          if (r5 == 5'h00) begin
            out = '{value: src, carry: src[31]};
          end else begin
            dbl = {src, src} >> r5;
            out = '{value: dbl[31:0], carry: dbl[31]};
          end
        end
      endcase
    end
  end

endmodule

// ===== core/alu_shifter_flag_unit.sv
// Purpose: Data-processing unit with shifter, flags and pc/status word
// Assumes: AHB-Lite slave, single word transfers, OKAY only
// Notes:   One operation per start; result and flags ready two cycles later
`timescale 1ns/1ns
module alu_shifter_flag_unit
  import alu_unit_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             DEST_WRITE,
  output logic      [31:0] PC_STATUS
);

  // -------------------------------------------------------------------
  // Bus slave
  // -------------------------------------------------------------------
  logic        wr_pend_reg;
  logic [7:0]  wr_addr_reg;
  logic [31:0] instr_reg;
  logic [31:0] opa_reg;
  logic [31:0] opb_reg;
  logic [31:0] count_reg;
  logic [5:2]  ctrl_reg;
  logic [31:0] pcreg_reg;
  logic [31:0] result_reg;
  logic        busy_reg;
  logic        done_reg;
  logic        wrote_reg;
  logic        go_reg;
  logic        addr_ok;
  logic [31:0] rd_word;

  assign addr_ok = HSEL && HREADY && HTRANS[1];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= addr_ok && HWRITE;
      wr_addr_reg <= HADDR[7:0];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      instr_reg <= 32'h00000000;
      opa_reg   <= 32'h00000000;
      opb_reg   <= 32'h00000000;
      count_reg <= 32'h00000000;
      ctrl_reg  <= 4'h0;
      go_reg    <= 1'b0;
    end else begin
      go_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          ADDR_INSTR: instr_reg <= HWDATA;
          ADDR_OPA:   opa_reg   <= HWDATA;
          ADDR_OPB:   opb_reg   <= HWDATA;
          ADDR_COUNT: count_reg <= HWDATA;
          ADDR_CTRL: begin
            ctrl_reg <= HWDATA[CTRL_D_PC:CTRL_A_PC];
            go_reg   <= HWDATA[CTRL_GO] && !busy_reg;
          end
          default: ;
        endcase
      end
    end
  end

  always_comb begin
    case (HADDR[7:0])
      ADDR_INSTR:  rd_word = instr_reg;
      ADDR_OPA:    rd_word = opa_reg;
      ADDR_OPB:    rd_word = opb_reg;
      ADDR_COUNT:  rd_word = count_reg;
      ADDR_CTRL:   rd_word = {26'h0000000, ctrl_reg, 2'h0};
      ADDR_PCREG:  rd_word = pcreg_reg;
      ADDR_RESULT: rd_word = result_reg;
      ADDR_STATE:  rd_word = {29'h00000000, wrote_reg, done_reg, busy_reg};
      default:     rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      HRDATA    <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (addr_ok && !HWRITE) begin
        HRDATA <= rd_word;
      end
    end
  end

  // -------------------------------------------------------------------
  // Operand preparation
  // -------------------------------------------------------------------
  instr_s      ins;
  shift_s      sh;
  logic [31:0] op1;
  logic [31:0] shsrc;
  logic [7:0]  amount;
  logic        c_old;
  logic [1:0]  mode;

  assign c_old = pcreg_reg[BIT_CARRY];
  assign mode  = pcreg_reg[1:0];

  always_comb begin
    ins.opcode     = instr_reg[24:21];
    ins.imm_sel    = instr_reg[25];
    ins.set_flags  = instr_reg[20];
    ins.shift_amt  = {3'h0, instr_reg[11:7]};
    ins.shift_type = instr_reg[6:5];
    ins.reg_shift  = instr_reg[4];
    ins.bit7       = instr_reg[7];  // caller keeps zero in register form
    ins.rot_field  = instr_reg[11:8];
    ins.imm8       = instr_reg[7:0];
  end

  assign op1   = ctrl_reg[CTRL_A_PC] ? (pcreg_reg & PC_MASK) : opa_reg;
  assign shsrc = ctrl_reg[CTRL_B_PC] ? pcreg_reg : opb_reg;
  assign amount = ins.reg_shift ?
                  (ctrl_reg[CTRL_S_PC] ? pcreg_reg[7:0] & PC_MASK[7:0] : count_reg[7:0])
                  : ins.shift_amt;

  barrel_shifter u_shift (
    .src       (shsrc),
    .amount    (amount),
    .kind      (ins.shift_type),
    .by_reg    (ins.reg_shift),
    .imm_sel   (ins.imm_sel),
    .imm8      (ins.imm8),
    .rot_field (ins.rot_field),
    .carry_in  (c_old),
    .out       (sh)
  );

  // -------------------------------------------------------------------
  // ALU
  // -------------------------------------------------------------------
  logic [31:0] op2;
  logic [32:0] sum;
  logic [31:0] res;
  logic        logical;
  logic        no_write;
  logic        ovf;

  assign op2 = sh.value;

  always_comb begin
    sum     = 33'h000000000;
    res     = 32'h00000000;
    logical = 1'b1;
    case (ins.opcode)
      OP_AND, OP_TEST_BITS:  res = op1 & op2;
      OP_XOR, OP_TEST_EQUIV: res = op1 ^ op2;
      OP_OR:                 res = op1 | op2;
      OP_BIT_CLEAR:          res = op1 & ~op2;
      OP_MOVE:               res = op2;
      OP_MOVE_INV:           res = ~op2;
      OP_SUB, OP_COMPARE: begin
        sum = {1'b0, op1} + {1'b0, ~op2} + 33'h000000001;
        logical = 1'b0;
      end
      OP_REV_SUB: begin
        sum = {1'b0, op2} + {1'b0, ~op1} + 33'h000000001;
        logical = 1'b0;
      end
      OP_ADD, OP_CMP_NEG: begin
        sum = {1'b0, op1} + {1'b0, op2};
        logical = 1'b0;
      end
      OP_ADD_CARRY: begin
        sum = {1'b0, op1} + {1'b0, op2} + {32'h00000000, c_old};
        logical = 1'b0;
      end
      OP_SUB_CARRY: begin
        sum = {1'b0, op1} + {1'b0, ~op2} + {32'h00000000, c_old};
        logical = 1'b0;
      end
      default: begin
        sum = {1'b0, op2} + {1'b0, ~op1} + {32'h00000000, c_old};
        logical = 1'b0;
      end
    endcase
    if (!logical) begin
      res = sum[31:0];
    end
  end

  assign no_write = (ins.opcode[3:2] == 2'b10);

  // Signed overflow from operand and result signs
  always_comb begin
    case (ins.opcode)
      OP_REV_SUB, OP_REV_SUB_C:
        ovf = (op2[31] != op1[31]) && (res[31] != op2[31]);
      OP_ADD, OP_ADD_CARRY, OP_CMP_NEG:
        ovf = (op1[31] == op2[31]) && (res[31] != op1[31]);
      default:
        ovf = (op1[31] != op2[31]) && (res[31] != op1[31]);
    endcase
  end

  // -------------------------------------------------------------------
  // Status and program counter update
  // -------------------------------------------------------------------
  logic        dest_pc;
  logic [31:0] allow;
  logic [31:0] pc_next;

  assign dest_pc = ctrl_reg[CTRL_D_PC];

  always_comb begin
    pc_next = pcreg_reg;
    allow   = (mode == MODE_USER) ? FLAG_MASK : STATUS_MASK;
    if (dest_pc) begin
      if (ins.set_flags) begin
        pc_next = (pcreg_reg & ~allow) | (res & allow);
        if (!no_write) begin
          pc_next = (pc_next & ~PC_MASK) | (res & PC_MASK);
        end
      end else if (!no_write) begin
        pc_next = (pcreg_reg & ~PC_MASK) | (res & PC_MASK);
      end
    end else if (ins.set_flags) begin
      pc_next[BIT_NEG]  = res[31];
      pc_next[BIT_ZERO] = (res == 32'h00000000);
      if (logical) begin
        pc_next[BIT_CARRY] = sh.carry;
      end else begin
        pc_next[BIT_CARRY] = sum[32];
        pc_next[BIT_OVF]   = ovf;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pcreg_reg  <= PCREG_RESET;
      result_reg <= 32'h00000000;
      busy_reg   <= 1'b0;
      done_reg   <= 1'b0;
      wrote_reg  <= 1'b0;
      DEST_WRITE <= 1'b0;
      PC_STATUS  <= PCREG_RESET;
    end else begin
      DEST_WRITE <= 1'b0;
      PC_STATUS  <= pcreg_reg;
      busy_reg   <= go_reg;
      if (wr_pend_reg && wr_addr_reg == ADDR_PCREG) begin
        pcreg_reg <= HWDATA;
      end else if (busy_reg) begin
        pcreg_reg <= pc_next;
      end
      if (busy_reg) begin
        done_reg   <= 1'b1;
        wrote_reg  <= !no_write;
        DEST_WRITE <= !no_write && !dest_pc;
        if (!no_write) begin
          result_reg <= res;
        end
      end else if (go_reg) begin
        done_reg <= 1'b0;
      end
    end
  end

  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  property p_test_no_write;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && no_write |=> !DEST_WRITE && $stable(result_reg);
  endproperty
  a_test_no_write: assert property (p_test_no_write) else $error("test op wrote");

  property p_move;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && ins.opcode == OP_MOVE |=> result_reg == $past(op2);
  endproperty
  a_move: assert property (p_move) else $error("move mismatch");

  property p_zero_flag;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && ins.set_flags && !dest_pc && !(wr_pend_reg && wr_addr_reg == ADDR_PCREG)
    |=> pcreg_reg[BIT_ZERO] == ($past(res) == 32'h00000000);
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong");

  property p_logic_ovf;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && logical && !dest_pc && !(wr_pend_reg && wr_addr_reg == ADDR_PCREG)
    |=> $stable(pcreg_reg[BIT_OVF]);
  endproperty
  a_logic_ovf: assert property (p_logic_ovf) else $error("overflow moved");

  property p_lsl32;
    @(posedge CLOCK) disable iff (RST)
    !ins.imm_sel && ins.reg_shift && ins.shift_type == SH_LEFT && amount == 8'd32
    |-> sh.value == 32'h00000000 && sh.carry == shsrc[0];
  endproperty
  a_lsl32: assert property (p_lsl32) else $error("left 32 wrong");

  property p_asr_big;
    @(posedge CLOCK) disable iff (RST)
    !ins.imm_sel && ins.reg_shift && ins.shift_type == SH_ARITH && amount >= 8'd32
    |-> sh.value == {32{shsrc[31]}} && sh.carry == shsrc[31];
  endproperty
  a_asr_big: assert property (p_asr_big) else $error("arith fill wrong");

  property p_pc_noflags;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && dest_pc && !ins.set_flags && !(wr_pend_reg && wr_addr_reg == ADDR_PCREG)
    |=> (pcreg_reg & STATUS_MASK) == ($past(pcreg_reg) & STATUS_MASK);
  endproperty
  a_pc_noflags: assert property (p_pc_noflags) else $error("status changed");

  property p_user_protect;
    @(posedge CLOCK) disable iff (RST)
    busy_reg && dest_pc && mode == MODE_USER && !(wr_pend_reg && wr_addr_reg == ADDR_PCREG)
    |=> pcreg_reg[1:0] == MODE_USER;
  endproperty
  a_user_protect: assert property (p_user_protect) else $error("mode changed");

  property p_op1_pc;
    @(posedge CLOCK) disable iff (RST)
    ctrl_reg[CTRL_A_PC] |-> (op1 & STATUS_MASK) == 32'h00000000;
  endproperty
  a_op1_pc: assert property (p_op1_pc) else $error("status on operand one");

  sequence s_run_done;
    busy_reg ##1 done_reg;
  endsequence
  property p_done;
    @(posedge CLOCK) disable iff (RST)
    go_reg |=> s_run_done;
  endproperty
  a_done: assert property (p_done) else $error("no completion");

endmodule

// ===== verification/testbench.sv
// Purpose: Self-checking bench for the data-processing unit
// Assumes: AHB-Lite master tasks, zero-wait slave, fixed seed
// Notes:   Expected values come from the bench's own shifter and ALU functions
`timescale 1ns/1ns
module testbench
  import alu_unit_pkg::*;
;
  logic        clock;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire logic   hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        dest_write;
  logic [31:0] pc_status;
  logic [31:0] processor_status_word;
  int          fails;
  int          tests_run;

  assign hready = hreadyout;

  alu_shifter_flag_unit u_dut (
    .CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hready),
    .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .DEST_WRITE(dest_write), .PC_STATUS(pc_status)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic end_of_test();
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Bus master
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge clock); while (hready !== 1'b1);
    q = hrdata;
  endtask

  // ---------------------------------------------------------------
  // Reference shifter and ALU
  // ---------------------------------------------------------------
  function automatic shift_s shf(logic [31:0] s, logic [31:0] ins, logic [7:0] c, logic ci);
    shift_s r;
    int     n;
    logic [63:0] w;
    n = ins[4] ? int'(c) : int'(ins[11:7]);
    r = '{s, ci};
    if (ins[25]) begin
      w = {2{24'h0, ins[7:0]}} >> (2 * ins[11:8]);
      r = '{w[31:0], (ins[11:8] == 4'h0) ? ci : w[31]};
    end else if (n == 0) begin
      if (!ins[4] && ins[6:5] == SH_ROT) r = '{{ci, s[31:1]}, s[0]};
    end else begin
      case (ins[6:5])
        SH_LEFT: begin
          w = {32'h0, s} << n;
          r = '{w[31:0], w[32]};
        end
        SH_RIGHT: begin
          w = {s, 32'h0} >> n;
          r = '{w[63:32], w[31]};
        end
        SH_ARITH: begin
          if (n > 32) n = 32;
          w = 64'($signed({s, 32'h0}) >>> n);
          r = '{w[63:32], w[31]};
        end
        default: begin
          n = (n - 1) % 32 + 1;
          w = {s, s} >> n;
          r = '{w[31:0], w[31]};
        end
      endcase
    end
    return r;
  endfunction

  function automatic logic [33:0] alu(logic [3:0] op, logic [31:0] a, logic [31:0] b,
                                      logic ci);
    logic [31:0] x;
    logic [31:0] y;
    logic        k;
    logic [32:0] t;
    x = a;
    y = b;
    k = 1'b0;
    case (op)
      4'h0, 4'h8: return {2'b0, a & b};
      4'h1, 4'h9: return {2'b0, a ^ b};
      4'hc: return {2'b0, a | b};
      4'hd: return {2'b0, b};
      4'he: return {2'b0, a & ~b};
      4'hf: return {2'b0, ~b};
      4'h2, 4'ha: begin y = ~b; k = 1'b1; end
      4'h3: begin x = b; y = ~a; k = 1'b1; end
      4'h5: k = ci;
      4'h6: begin y = ~b; k = ci; end
      4'h7: begin x = b; y = ~a; k = ci; end
      default: k = 1'b0;
    endcase
    t = {1'b0, x} + {1'b0, y} + 33'(k);
    return {t[32], (x[31] == y[31]) && (t[31] != x[31]), t[31:0]};
  endfunction

  // One operation through the bus, then flags, pc word and write pulse
  task automatic run(input logic [31:0] ins, input logic [31:0] a, input logic [31:0] b,
                     input logic [31:0] cnt, input logic [31:0] ctl);
    shift_s      sh;
    logic [33:0] r;
    logic [31:0] m;
    logic [31:0] q;
    logic [3:0]  op;
    logic        lg;
    logic        tst;
    int          dw;
    op  = ins[24:21];
    lg  = !(op inside {[4'h2:4'h7], 4'ha, 4'hb});
    tst = (op[3:2] == 2'b10);
    sh  = shf(ctl[3] ? processor_status_word : b, ins, ctl[4] ? 8'(processor_status_word & PC_MASK) : cnt[7:0], processor_status_word[29]);
    r   = alu(op, ctl[2] ? (processor_status_word & PC_MASK) : a, sh.value, processor_status_word[29]);
    bus(1'b1, ADDR_INSTR, ins, q);
    bus(1'b1, ADDR_OPA, a, q);
    bus(1'b1, ADDR_OPB, b, q);
    bus(1'b1, ADDR_COUNT, cnt, q);
    bus(1'b1, ADDR_CTRL, ctl | 32'h1, q);
    dw = 0;
    repeat (6) @(posedge clock) dw += (dest_write === 1'b1);
    if (ctl[5]) begin
      if (ins[20]) begin
        m = (processor_status_word[1:0] == MODE_USER) ? FLAG_MASK : STATUS_MASK;
        if (!tst) m = m | PC_MASK;
      end else begin
        m = tst ? 32'h0 : PC_MASK;
      end
      processor_status_word = (processor_status_word & ~m) | (r[31:0] & m);
    end else if (ins[20]) begin
      processor_status_word[31:28] = {r[31], r[31:0] == 32'h0, lg ? sh.carry : r[33], lg ? processor_status_word[28] : r[32]};
    end
    check(pc_status, processor_status_word);
    check(32'(dw), 32'(!tst && !ctl[5]));
    if (!tst && !ctl[5]) begin
      bus(1'b0, ADDR_RESULT, 32'h0, q);
      check(q, r[31:0]);
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  logic [31:0] corner [9] = '{0, 1, 31, 32, 33, 64, 255, 32'h100, 32'h121};

  initial begin : main
    logic [31:0] q;
    logic [31:0] ins;
    logic [31:0] ctl;
    fails = 0;
    tests_run = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    void'($urandom(32'h5e005f55));
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check(pc_status, PCREG_RESET);
    check({30'h0, hresp, hreadyout}, 32'h1);
    processor_status_word = PCREG_RESET;
    bus(1'b0, 8'h40, 32'h0, q);
    check(q, 32'h0);
    for (int t = 0; t < 4; t++) begin
      for (int c = 0; c < 9; c++)
        run(32'h01b00010 | (t << 5), $urandom, $urandom, corner[c], 32'h0);
      run(32'h01b00000 | (t << 5) | ((t % 3) ? 32'h80 : 32'h0), 0, $urandom, 0, 0);
    end
    for (int i = 0; i < 200; i++) begin
      if (i % 4 == 0) begin
        processor_status_word = $urandom;
        bus(1'b1, ADDR_PCREG, processor_status_word, q);
      end
      ins = $urandom;
      ins[24:21] = i[3:0];
      if (!ins[25] && ins[4]) ins[7] = 1'b0;
      if (!ins[25] && !ins[4] && ins[11:7] == 5'h0 && ins[6:5] inside {SH_RIGHT, SH_ARITH})
        ins[7] = 1'b1;
      ctl = $urandom & 32'h3c;
      if (ins[24:23] == 2'b10 && !ins[20]) ctl[5] = 1'b0;
      run(ins, $urandom, $urandom, $urandom % 70, ctl);
    end
    end_of_test();
  end

  initial begin
    repeat (40000) @(posedge clock);
    fails++;
    end_of_test();
  end
endmodule
